// *** rtl/spmsp_top.sv ***
// module: serial master/slave port with register port and pins
`timescale 1ns/1ps
`default_nettype none

// Contract
// - shift out and in simultaneously
// - master data line sends msb first
// - slave data line sends msb first
// - eight serial clocks per byte
// - unselected slave floats its data output
// - master watches select with mode fault
// - master with select-disable never faults
// - slave phase1 select-disable always selected
// - clearing select-disable keeps mode fault
// - rate field divides clock, 111 none
// - mode fault can raise interrupt
// - master-select chooses master or slave
// - byte end sets flag, loads receive
// - select low faults, clears enable, master
// - data write during transfer flags collision
module spmsp_top (
    input wire logic clock,
    input wire logic reset,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    input wire spmsp_pkg::spmsp_pin_in_t pin_in,
    output spmsp_pkg::spmsp_pin_out_t pin_out
);

    // ==========================================================
    // decoding helpers
    // ==========================================================
    // half serial period in clocks for a rate code
    function automatic logic [6:0] half_period(input logic [2:0] code);
        begin
            half_period = spmsp_pkg::HALF_BASE << code;
        end
    endfunction

    // rate code gathered from the control register
    function automatic logic [2:0] rate_of(input logic [7:0] c);
        begin
            rate_of = {c[spmsp_pkg::CTRL_RATE2], c[spmsp_pkg::CTRL_RATE1],
                c[spmsp_pkg::CTRL_RATE0]};
        end
    endfunction

    // ==========================================================
    // state
    // ==========================================================
    spmsp_pkg::spmsp_regs_t q_ff; // registered state
    spmsp_pkg::spmsp_regs_t nxt_q; // next state
    logic en; // port enabled
    logic master_select; // master mode
    logic cpha; // clock phase
    logic cpol; // clock polarity
    logic select_disable; // select disabled
    logic sel; // slave selected
    logic wr_ctrl; // control write
    logic rd_stat; // status read
    logic rd_data; // data read
    logic wr_data; // data write

    assign en = q_ff.ctrl[spmsp_pkg::CTRL_EN];
    assign master_select = q_ff.ctrl[spmsp_pkg::CTRL_MASTER_SELECT];
    assign cpha = q_ff.ctrl[spmsp_pkg::CTRL_CPHA];
    assign cpol = q_ff.ctrl[spmsp_pkg::CTRL_CPOL];
    assign select_disable = q_ff.ctrl[spmsp_pkg::CTRL_SELECT_DISABLE];
    assign sel = !pin_in.ss_n || (cpha && select_disable);
    assign wr_ctrl = wr && (addr == spmsp_pkg::ADDR_CTRL);
    assign rd_stat = rd && (addr == spmsp_pkg::ADDR_STAT);
    assign rd_data = rd && (addr == spmsp_pkg::ADDR_DATA);
    assign wr_data = wr && (addr == spmsp_pkg::ADDR_DATA);

    // ==========================================================
    // next-state logic
    // ==========================================================
    // register port, serial engine, faults and pin drive
    always_comb
    begin
        logic do_edge; // a serial clock edge occurs now
        logic leading; // the edge leaves the idle level
        logic din; // serial data input for this mode
        logic [7:0] rx_byte; // completed byte
        do_edge = 1'b0;
        leading = 1'b0;
        din = 1'b0;
        rx_byte = 8'h00;
        nxt_q = q_ff;
        nxt_q.rdata = 8'h00;

        // read data, valid one cycle after the strobe
        if (rd)
        begin
            unique case (addr)
                spmsp_pkg::ADDR_CTRL: nxt_q.rdata = q_ff.ctrl;
                spmsp_pkg::ADDR_STAT:
                begin
                    nxt_q.rdata[spmsp_pkg::STAT_TC] = q_ff.tc;
                    nxt_q.rdata[spmsp_pkg::STAT_WRITE_COLLISION_FLAG] = q_ff.write_collision_flag;
                    nxt_q.rdata[spmsp_pkg::STAT_SSERR] = q_ff.sserr;
                    nxt_q.rdata[spmsp_pkg::STAT_MF] = q_ff.mf;
                    nxt_q.rdata[spmsp_pkg::STAT_BUSY] = q_ff.state;
                end
                spmsp_pkg::ADDR_DATA: nxt_q.rdata = q_ff.rx;
                default: nxt_q.rdata = 8'h00; // unmapped reads zero
            endcase
        end

        // status read arms the clearing sequences
        if (rd_stat)
        begin
            nxt_q.tc_arm = q_ff.tc;
            nxt_q.write_collision_flag_arm = q_ff.write_collision_flag;
            nxt_q.mf_arm = q_ff.mf;
        end
        // data read after armed status read clears transfer complete
        if (rd_data && q_ff.tc_arm)
        begin
            nxt_q.tc = 1'b0;
            nxt_q.tc_arm = 1'b0;
        end
        // any data access after armed status read clears collision
        if ((rd_data || wr_data) && q_ff.write_collision_flag_arm)
        begin
            nxt_q.write_collision_flag = 1'b0;
            nxt_q.write_collision_flag_arm = 1'b0;
        end

        // control write; mode fault only cleared by its own sequence
        if (wr_ctrl)
        begin
            nxt_q.ctrl = wdata;
            if (q_ff.mf_arm)
            begin
                nxt_q.mf = 1'b0;
                nxt_q.mf_arm = 1'b0;
            end
            if (!wdata[spmsp_pkg::CTRL_EN])
                nxt_q.sserr = 1'b0;
        end

        // data write: collision while busy, else load shift register if enabled
        if (wr_data)
        begin
            if (q_ff.state == spmsp_pkg::SPMSP_XFER)
                nxt_q.write_collision_flag = 1'b1;
            else if (en)
            begin
                nxt_q.sh = wdata;
                if (master_select)
                begin
                    nxt_q.state = spmsp_pkg::SPMSP_XFER;
                    nxt_q.edge_cnt = spmsp_pkg::EDGE_RESET;
                    nxt_q.div_cnt = spmsp_pkg::DIV_RESET;
                end
            end
        end

        nxt_q.sck_prev = pin_in.sck;
        // master engine: divider makes the serial clock edges
        if (en && master_select && q_ff.state == spmsp_pkg::SPMSP_XFER)
        begin
            if (rate_of(q_ff.ctrl) != spmsp_pkg::RATE_NONE)
            begin
                if (q_ff.div_cnt + 7'h01 == half_period(rate_of(q_ff.ctrl)))
                begin
                    nxt_q.div_cnt = spmsp_pkg::DIV_RESET;
                    do_edge = 1'b1;
                    leading = (q_ff.pin_out.sck_out == cpol);
                    nxt_q.pin_out.sck_out = !q_ff.pin_out.sck_out;
                end
                else
                    nxt_q.div_cnt = q_ff.div_cnt + 7'h01;
            end
            din = pin_in.miso;
        end
        // slave engine: edges come from the serial clock input
        else if (en && !master_select)
        begin
            din = pin_in.mosi;
            if (!sel)
            begin
                if (q_ff.state == spmsp_pkg::SPMSP_XFER)
                    nxt_q.sserr = 1'b1;
                nxt_q.state = spmsp_pkg::SPMSP_IDLE;
                nxt_q.edge_cnt = spmsp_pkg::EDGE_RESET;
            end
            else if (pin_in.sck != q_ff.sck_prev)
            begin
                do_edge = 1'b1;
                leading = (q_ff.sck_prev == cpol);
                nxt_q.state = spmsp_pkg::SPMSP_XFER;
            end
        end

        // shared edge handling for all four clock modes
        if (do_edge)
        begin
            if (leading ^ cpha)
                nxt_q.samp = din;
            else if (!(cpha && q_ff.edge_cnt == spmsp_pkg::EDGE_RESET))
                nxt_q.sh = {q_ff.sh[6:0], q_ff.samp};
            if (q_ff.edge_cnt == spmsp_pkg::LAST_EDGE)
            begin
                rx_byte = cpha ? {q_ff.sh[6:0], din} : {q_ff.sh[6:0], q_ff.samp};
                nxt_q.rx = rx_byte;
                nxt_q.sh = rx_byte;
                nxt_q.tc = 1'b1;
                nxt_q.state = spmsp_pkg::SPMSP_IDLE;
                nxt_q.edge_cnt = spmsp_pkg::EDGE_RESET;
            end
            else
                nxt_q.edge_cnt = q_ff.edge_cnt + 4'h1;
        end

        // mode fault: select pulled low while master
        if (en && master_select && !select_disable && !pin_in.ss_n)
        begin
            nxt_q.mf = 1'b1;
            nxt_q.ctrl[spmsp_pkg::CTRL_EN] = 1'b0;
            nxt_q.ctrl[spmsp_pkg::CTRL_MASTER_SELECT] = 1'b0;
        end

        // disabled port stops any byte in flight
        if (!nxt_q.ctrl[spmsp_pkg::CTRL_EN])
        begin
            nxt_q.state = spmsp_pkg::SPMSP_IDLE;
            nxt_q.edge_cnt = spmsp_pkg::EDGE_RESET;
        end

        // pin drive from the next state
        if (!(nxt_q.ctrl[spmsp_pkg::CTRL_MASTER_SELECT] && nxt_q.state == spmsp_pkg::SPMSP_XFER))
            nxt_q.pin_out.sck_out = nxt_q.ctrl[spmsp_pkg::CTRL_CPOL];
        nxt_q.pin_out.sck_oe_n = !(nxt_q.ctrl[spmsp_pkg::CTRL_EN]
            && nxt_q.ctrl[spmsp_pkg::CTRL_MASTER_SELECT]);
        nxt_q.pin_out.mosi_oe_n = nxt_q.pin_out.sck_oe_n;
        nxt_q.pin_out.mosi_out = nxt_q.sh[7];
        nxt_q.pin_out.miso_out = nxt_q.sh[7];
        nxt_q.pin_out.miso_oe_n = !(nxt_q.ctrl[spmsp_pkg::CTRL_EN]
            && !nxt_q.ctrl[spmsp_pkg::CTRL_MASTER_SELECT] && sel);
        nxt_q.irq = nxt_q.tc || (nxt_q.mf && !nxt_q.ctrl[spmsp_pkg::CTRL_SELECT_DISABLE]);
    end

    // ==========================================================
    // state register
    // ==========================================================
    // synchronous reset to an idle, disabled port
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            q_ff <= '0;
            q_ff.ctrl <= spmsp_pkg::CTRL_RESET;
            q_ff.sh <= spmsp_pkg::DATA_RESET;
            q_ff.rx <= spmsp_pkg::DATA_RESET;
            q_ff.pin_out.sck_oe_n <= 1'b1;
            q_ff.pin_out.mosi_oe_n <= 1'b1;
            q_ff.pin_out.miso_oe_n <= 1'b1;
        end
        else
            q_ff <= nxt_q;
    end

    assign rdata = q_ff.rdata;
    assign irq = q_ff.irq;
    assign pin_out = q_ff.pin_out;

    // ==========================================================
    // assertions
    // ==========================================================
    logic [4:0] tog_cnt_ff; // serial clock toggles in a master byte

    // helper: counts master clock toggles since the byte started
    always_ff @(posedge clock)
    begin
        if (reset || (wr_data && q_ff.state == spmsp_pkg::SPMSP_IDLE))
            tog_cnt_ff <= 5'h00;
        else if (q_ff.pin_out.sck_out != nxt_q.pin_out.sck_out)
            tog_cnt_ff <= tog_cnt_ff + 5'h01;
    end

    property p_reset_idle;
        @(posedge clock) disable iff (reset)
        $fell(reset) |-> (q_ff.state == spmsp_pkg::SPMSP_IDLE) && !q_ff.tc
            && !q_ff.mf && !q_ff.write_collision_flag && q_ff.pin_out.sck_oe_n;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("port not idle after reset");

    property p_fault_clears;
        @(posedge clock) disable iff (reset)
        $rose(q_ff.mf) |-> !q_ff.ctrl[spmsp_pkg::CTRL_EN]
            && !q_ff.ctrl[spmsp_pkg::CTRL_MASTER_SELECT] && q_ff.irq ##1 q_ff.pin_out.sck_oe_n;
    endproperty
    a_fault_clears: assert property (p_fault_clears)
        else $error("mode fault did not stop master");

    property p_select_disable_no_fault;
        @(posedge clock) disable iff (reset)
        (master_select && select_disable && !q_ff.mf && !wr_ctrl) |=> !q_ff.mf;
    endproperty
    a_select_disable_no_fault: assert property (p_select_disable_no_fault)
        else $error("mode fault set with select disabled");

    property p_miso_float;
        @(posedge clock) disable iff (reset)
        (!master_select && pin_in.ss_n && !(cpha && select_disable) && !wr_ctrl) |=> q_ff.pin_out.miso_oe_n;
    endproperty
    a_miso_float: assert property (p_miso_float)
        else $error("unselected slave drives data out");

    property p_forced_select;
        @(posedge clock) disable iff (reset)
        (en && !master_select && cpha && select_disable && !wr_ctrl) |=> !q_ff.pin_out.miso_oe_n;
    endproperty
    a_forced_select: assert property (p_forced_select)
        else $error("forced-select slave not driving");

    property p_fast_rate;
        @(posedge clock) disable iff (reset)
        (en && master_select && q_ff.state == spmsp_pkg::SPMSP_XFER && pin_in.ss_n
            && rate_of(q_ff.ctrl) == 3'h0 && !wr_ctrl)
            |=> q_ff.pin_out.sck_out != $past(q_ff.pin_out.sck_out);
    endproperty
    a_fast_rate: assert property (p_fast_rate)
        else $error("divide-by-two rate not toggling");

    property p_no_rate;
        @(posedge clock) disable iff (reset)
        (master_select && rate_of(q_ff.ctrl) == spmsp_pkg::RATE_NONE && !wr) |=> $stable(q_ff.pin_out.sck_out);
    endproperty
    a_no_rate: assert property (p_no_rate)
        else $error("serial clock moved on reserved rate");

    property p_sixteen_edges;
        @(posedge clock) disable iff (reset)
        ($rose(q_ff.tc) && master_select) |-> tog_cnt_ff == 5'h10;
    endproperty
    a_sixteen_edges: assert property (p_sixteen_edges)
        else $error("master byte not eight clocks");

    property p_tc_loads_rx;
        @(posedge clock) disable iff (reset)
        $rose(q_ff.tc) |-> $past(q_ff.state) == spmsp_pkg::SPMSP_XFER && q_ff.rx == q_ff.sh;
    endproperty
    a_tc_loads_rx: assert property (p_tc_loads_rx)
        else $error("receive register not loaded at byte end");

    property p_collision;
        @(posedge clock) disable iff (reset)
        (wr_data && q_ff.state == spmsp_pkg::SPMSP_XFER)
            |=> (q_ff.write_collision_flag && q_ff.state == spmsp_pkg::SPMSP_XFER) or q_ff.tc;
    endproperty
    a_collision: assert property (p_collision)
        else $error("collision not flagged");

    property p_msb_first;
        @(posedge clock) disable iff (reset)
        (wr_data && en && master_select && q_ff.state == spmsp_pkg::SPMSP_IDLE && pin_in.ss_n)
            |=> q_ff.pin_out.mosi_out == $past(wdata[7]);
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first master bit is not msb");

    c_master_byte: cover property (@(posedge clock) disable iff (reset) $rose(q_ff.tc) && master_select);
    c_slave_byte: cover property (@(posedge clock) disable iff (reset) $rose(q_ff.tc) && !master_select);
    c_mode_fault: cover property (@(posedge clock) disable iff (reset) $rose(q_ff.mf));
    c_collision: cover property (@(posedge clock) disable iff (reset) $rose(q_ff.write_collision_flag));

endmodule
`default_nettype wire

// *** rtl/spmsp_pkg.sv ***
// package: constants and types of the serial master/slave port
package spmsp_pkg;

    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS = 10; // 100 MHz clock
    localparam logic [3:0] LAST_EDGE = 4'hF; // sixteen clock edges per byte
    localparam logic [2:0] RATE_NONE = 3'h7; // reserved code, no rate
    localparam logic [6:0] HALF_BASE = 7'h01; // half period at code 000

    // ==========================================================
    // register map (address port is two bits)
    // ==========================================================
    localparam logic [1:0] ADDR_CTRL = 2'h0; // serial_port_control_reg
    localparam logic [1:0] ADDR_STAT = 2'h1; // serial_port_status_reg
    localparam logic [1:0] ADDR_DATA = 2'h2; // serial_port_data_reg

    // control field positions
    localparam int unsigned CTRL_RATE0 = 0; // rate_sel_bit0
    localparam int unsigned CTRL_RATE1 = 1; // rate_sel_bit1
    localparam int unsigned CTRL_CPHA = 2; // clock phase
    localparam int unsigned CTRL_CPOL = 3; // clock polarity
    localparam int unsigned CTRL_MASTER_SELECT = 4; // master_select
    localparam int unsigned CTRL_SELECT_DISABLE = 5; // select_disable
    localparam int unsigned CTRL_EN = 6; // port_enable
    localparam int unsigned CTRL_RATE2 = 7; // rate_sel_bit2

    // status field positions
    localparam int unsigned STAT_TC = 7; // transfer_complete_flag
    localparam int unsigned STAT_WRITE_COLLISION_FLAG = 6; // write_collision_flag
    localparam int unsigned STAT_SSERR = 5; // select lost mid byte
    localparam int unsigned STAT_MF = 4; // mode_fault_flag
    localparam int unsigned STAT_BUSY = 0; // transfer in progress

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [6:0] DIV_RESET = 7'h00;
    localparam logic [3:0] EDGE_RESET = 4'h0;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [0:0] {
        SPMSP_IDLE = 1'b0,
        SPMSP_XFER = 1'b1
    } spmsp_state_t;

    // pins seen by the port
    typedef struct packed {
        logic sck; // serial clock input (slave)
        logic mosi; // master-to-slave data input (slave)
        logic miso; // slave-to-master data input (master)
        logic ss_n; // select input, active low
    } spmsp_pin_in_t;

    // pins driven by the port, enables active low
    typedef struct packed {
        logic sck_out;
        logic sck_oe_n;
        logic mosi_out;
        logic mosi_oe_n;
        logic miso_out;
        logic miso_oe_n;
    } spmsp_pin_out_t;

    // complete state of the port
    typedef struct packed {
        spmsp_state_t state;
        logic [7:0] ctrl; // control register
        logic tc; // transfer complete
        logic write_collision_flag; // write collision
        logic sserr; // select error
        logic mf; // mode fault
        logic tc_arm; // status seen with tc set
        logic write_collision_flag_arm; // status seen with write_collision_flag set
        logic mf_arm; // status seen with mf set
        logic [7:0] sh; // shift register
        logic [7:0] rx; // receive data register
        logic samp; // bit caught on the sample edge
        logic [3:0] edge_cnt; // serial clock edges in this byte
        logic [6:0] div_cnt; // rate divider
        logic sck_prev; // previous serial clock input
        spmsp_pin_out_t pin_out;
        logic irq;
        logic [7:0] rdata;
    } spmsp_regs_t;

endpackage

// *** testbench/spmsp_partner.sv ***
// far-side model: a slave answering the port and a master driving it
`timescale 1ns/1ps
`default_nettype none
module spmsp_partner (
    input wire logic clock,
    input wire logic sck_w,
    input wire logic mosi_w,
    input wire logic miso_w,
    output logic s_miso,
    output logic m_sck,
    output logic m_mosi,
    output logic m_ss_n
);
    // ============
    // slave side
    // ============
    localparam int HALF = 6; // clocks per serial clock level when driving
    logic [7:0] sh; // byte going back to the port
    logic [7:0] got; // byte taken from the port
    logic pol, pha, first, act, tog;
    initial
    begin
        {sh, got, pol, pha, first, act, tog} = '0;
        {m_sck, m_mosi, m_ss_n} = 3'h1;
    end
    // a released line keeps moving so a stale bit never passes
    always @(posedge clock) tog <= !tog;
    assign s_miso = act ? sh[7] : tog;
    // sample or shift on each serial clock edge as the mode says
    always @(sck_w)
    begin
        if (act)
        begin
            if ((sck_w != pol) ^ pha)
                got = {got[6:0], mosi_w};
            else if (pha && first)
                first = 1'h0;
            else
                sh = {sh[6:0], !sh[7]};
        end
    end
    // arm the slave with its answer byte and mode
    task automatic load(input logic [7:0] b, input logic p, input logic h);
        {sh, got, pol, pha, first, act} = {b, 8'h00, p, h, 2'h3};
    endtask
    // ============
    // master side
    // ============
    // one byte as master, select held low for the whole byte when use_ss is set, else left high
    task automatic mbyte(input logic p, h, use_ss, input logic [7:0] tx,
        output logic [7:0] rx);
        act = 1'h0;
        m_sck <= p;
        repeat (HALF) @(posedge clock);
        m_ss_n <= !use_ss;
        m_mosi <= tx[7];
        repeat (HALF) @(posedge clock);
        for (int i = 0; i < 8; i++)
        begin
            m_sck <= !p;
            if (h)
                m_mosi <= tx[7 - i];
            else
                rx[7 - i] = miso_w;
            repeat (HALF) @(posedge clock);
            m_sck <= p;
            if (h)
                rx[7 - i] = miso_w;
            else if (i < 7)
                m_mosi <= tx[6 - i];
            repeat (HALF) @(posedge clock);
        end
        m_ss_n <= 1'h1;
        m_mosi <= !tx[0];
        repeat (HALF) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// *** testbench/spmsp_top_tb.sv ***
// testbench: register port, master and slave transfers, faults
`timescale 1ns/1ps
`default_nettype none
module spmsp_top_tb;
    // ============
    // signals
    // ============
    logic clock, reset, wr, rd, irq, ss_n, meas, last;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, d;
    logic sck_w, mosi_w, miso_w, s_miso, m_sck, m_mosi, m_ss_n;
    spmsp_pkg::spmsp_pin_in_t pin_in;
    spmsp_pkg::spmsp_pin_out_t pin_out;
    int err_count, comparisons, cyc, seed, ntog, gap, h;
    // wire levels from every party's enable
    assign sck_w = pin_out.sck_oe_n ? m_sck : pin_out.sck_out;
    assign mosi_w = pin_out.mosi_oe_n ? m_mosi : pin_out.mosi_out;
    assign miso_w = pin_out.miso_oe_n ? s_miso : pin_out.miso_out;
    assign pin_in = {sck_w, mosi_w, miso_w, ss_n & m_ss_n};
    spmsp_top dut_u (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq), .pin_in(pin_in), .pin_out(pin_out));
    spmsp_partner part_u (.clock(clock), .sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w),
        .s_miso(s_miso), .m_sck(m_sck), .m_mosi(m_mosi), .m_ss_n(m_ss_n));
    initial
    begin
        clock = 1'h0;
        forever #5 clock = !clock;
    end
    // ============
    // helpers
    // ============
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1'h1;
        @(posedge clock);
        wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] q);
        @(posedge clock);
        addr <= a;
        rd <= 1'h1;
        @(posedge clock);
        rd <= 1'h0;
        #1 q = rdata;
    endtask
    // expected control byte
    function automatic logic [7:0] ctl(input logic en, ss, ms, input logic [1:0] md,
        input logic [2:0] code);
        return {code[2], en, ss, ms, md, code[1:0]};
    endfunction
    // timeout and serial clock spacing while a byte runs
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            err_count++;
            end_sim();
        end
        if (meas && pin_out.sck_out !== last)
        begin
            if (ntog > 0)
                check(8'(gap), 8'(h));
            ntog++;
            gap = 1;
        end
        else
            gap++;
        last = pin_out.sck_out;
    end
    // one byte with the port as master
    task automatic mxfer(input logic [1:0] md, input logic [2:0] code, input logic coll);
        logic [7:0] tx, rx;
        tx = 8'($random(seed));
        rx = 8'($random(seed));
        wr_reg(spmsp_pkg::ADDR_CTRL, ctl(0, 0, 1, md, code));
        wr_reg(spmsp_pkg::ADDR_CTRL, ctl(1, 0, 1, md, code));
        repeat (2) @(posedge clock);
        part_u.load(rx, md[1], md[0]);
        {ntog, h, meas} = {32'h0, 32'h1 << code, 1'h1};
        wr_reg(spmsp_pkg::ADDR_DATA, tx);
        if (coll)
            wr_reg(spmsp_pkg::ADDR_DATA, ~tx);
        for (int i = 0; i < 2200 && irq !== 1'h1; i++) @(posedge clock);
        repeat (2) @(posedge clock);
        meas = 1'h0;
        check({7'h0, irq}, 8'h01);
        check(8'(ntog), 8'h10);
        check(part_u.got, tx);
        check({7'h0, pin_out.sck_out}, {7'h0, md[1]});
        rd_reg(spmsp_pkg::ADDR_STAT, d);
        check(d, {1'h1, coll, 6'h00});
        rd_reg(spmsp_pkg::ADDR_DATA, d);
        check(d, rx);
        rd_reg(spmsp_pkg::ADDR_STAT, d);
        check(d, 8'h00);
    endtask
    // one byte with the port as slave
    task automatic sxfer(input logic [1:0] md, input logic ss);
        logic [7:0] tx, mt, mr;
        tx = 8'($random(seed));
        mt = 8'($random(seed));
        wr_reg(spmsp_pkg::ADDR_CTRL, ctl(0, ss, 0, md, 3'h0));
        wr_reg(spmsp_pkg::ADDR_CTRL, ctl(1, ss, 0, md, 3'h0));
        wr_reg(spmsp_pkg::ADDR_DATA, tx);
        repeat (2) @(posedge clock);
        if (!ss)
            check({7'h0, pin_out.miso_oe_n}, 8'h01);
        part_u.mbyte(md[1], md[0], !ss, mt, mr);
        check(mr, tx);
        rd_reg(spmsp_pkg::ADDR_STAT, d);
        check(d, 8'h80);
        rd_reg(spmsp_pkg::ADDR_DATA, d);
        check(d, mt);
        if (!ss)
            check({7'h0, pin_out.miso_oe_n}, 8'h01);
        wr_reg(spmsp_pkg::ADDR_CTRL, 8'h00);
    endtask
    // ============
    // main sequence
    // ============
    initial
    begin
        {err_count, comparisons, cyc, ntog, gap, h} = '0;
        {reset, wr, rd, addr, wdata, ss_n, meas, last} = {1'h1, 12'h0, 1'h1, 2'h0};
        seed = 32'h6cd3d5f9;
        repeat (10) @(posedge clock);
        reset <= 1'h0;
        rd_reg(spmsp_pkg::ADDR_CTRL, d);
        check(d, spmsp_pkg::CTRL_RESET);
        rd_reg(spmsp_pkg::ADDR_STAT, d);
        check(d, 8'h00);
        check({4'h0, irq, pin_out.sck_oe_n, pin_out.mosi_oe_n, pin_out.miso_oe_n}, 8'h07);
        wr_reg(2'h3, 8'hFF);
        rd_reg(2'h3, d);
        check(d, 8'h00);
        for (int i = 0; i < 7; i++) mxfer(2'(i), 3'(i), 1'h0);
        mxfer(2'h1, 3'h2, 1'h1);
        // reserved rate code: no serial clock, byte never ends
        wr_reg(spmsp_pkg::ADDR_CTRL, ctl(1, 0, 1, 2'h0, 3'h7));
        {ntog, meas} = {32'h0, 1'h1};
        wr_reg(spmsp_pkg::ADDR_DATA, 8'h5A);
        repeat (100) @(posedge clock);
        meas = 1'h0;
        check(8'(ntog), 8'h00);
        rd_reg(spmsp_pkg::ADDR_STAT, d);
        check(d, 8'h01);
        wr_reg(spmsp_pkg::ADDR_CTRL, 8'h00);
        // select pulled low under an enabled master
        wr_reg(spmsp_pkg::ADDR_CTRL, ctl(1, 0, 1, 2'h0, 3'h0));
        ss_n <= 1'h0;
        repeat (3) @(posedge clock);
        check({5'h0, irq, pin_out.sck_oe_n, pin_out.mosi_oe_n}, 8'h07);
        rd_reg(spmsp_pkg::ADDR_CTRL, d);
        check(d, 8'h00);
        wr_reg(spmsp_pkg::ADDR_CTRL, 8'h20);
        wr_reg(spmsp_pkg::ADDR_CTRL, 8'h00);
        rd_reg(spmsp_pkg::ADDR_STAT, d);
        check(d, 8'h10);
        wr_reg(spmsp_pkg::ADDR_CTRL, 8'h00);
        rd_reg(spmsp_pkg::ADDR_STAT, d);
        check(d, 8'h00);
        // select freed for general use under a master
        wr_reg(spmsp_pkg::ADDR_CTRL, ctl(1, 1, 1, 2'h0, 3'h0));
        repeat (3) @(posedge clock);
        rd_reg(spmsp_pkg::ADDR_STAT, d);
        check(d, 8'h00);
        rd_reg(spmsp_pkg::ADDR_CTRL, d);
        check(d, 8'h70);
        ss_n <= 1'h1;
        wr_reg(spmsp_pkg::ADDR_CTRL, 8'h00);
        for (int i = 0; i < 4; i++) sxfer(2'(i), 1'h0);
        sxfer(2'h3, 1'h1);
        end_sim();
    end
endmodule
`default_nettype wire
